/* File: rtl/cfgdec_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cfgdec_top #(
   parameter int NUM_LDEV = cfgdec_pkg::NUM_LDEV
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_b,
   input  wire logic                        host_bus_reset_n,
   input  wire cfgdec_pkg::cfgdec_io_t      io,
   output logic [7:0]                       rdata,
   output logic                             rdata_valid,
   output cfgdec_pkg::cfgdec_reg_wr_t       reg_wr,
   output logic                             reg_wr_valid,
   input  wire logic [7:0]                  reg_rdata,
   input  wire logic                        gpio_in_pin,
   output logic                             gpio_in,
   output logic                             in_config,
   output logic [15:0]                      cfg_port_addr,
   output logic [NUM_LDEV-1:0]              ldev_active
);
   cfgdec_pkg::cfgdec_state_t state_reg;
   logic [7:0]  index_reg;
   logic [7:0]  ldn_reg;
   logic [7:0]  cfg_port_addr_low;
   logic [7:0]  cfg_port_addr_high;
   logic        strap_reg;
   logic        host_reset_sync;
   logic        strap_load;
   logic        strap_apply_reg;
   logic        soft_rst;
   logic        key_hit;
   logic        data_hit;
   logic        idx_wr;
   logic        data_wr;
   logic        data_rd;
   logic [15:0] port_base;
   logic [1:0]  gpio_sync_reg;

   // --------------------------------------------------------------
   // Strap capture
   // --------------------------------------------------------------
   cfgdec_strap cfgdec_strap_inst (
      .ref_clk          (ref_clk),
      .rst_b            (rst_b),
      .host_bus_reset_n (host_bus_reset_n),
      .strap_pin        (gpio_in_pin),
      .strap_reg        (strap_reg),
      .host_reset_sync  (host_reset_sync),
      .strap_load       (strap_load)
   );

   // Same pin feeds GPIO; strap only matters at reset
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         gpio_sync_reg <= 2'h0;
      end else begin
         gpio_sync_reg <= {gpio_sync_reg[0], gpio_in_pin};
      end
   end
   assign gpio_in = gpio_sync_reg[1];

   // --------------------------------------------------------------
   // Decode
   // --------------------------------------------------------------
   assign soft_rst  = host_reset_sync;
   assign port_base = {cfg_port_addr_high, cfg_port_addr_low};
   assign key_hit   = (io.addr == port_base);
   assign data_hit  = (io.addr == port_base + cfgdec_pkg::DATA_PORT_STEP);
   assign idx_wr    = io.wr & key_hit & (state_reg == cfgdec_pkg::CFGDEC_CONFIG);
   assign data_wr   = io.wr & data_hit & (state_reg == cfgdec_pkg::CFGDEC_CONFIG);
   assign data_rd   = io.rd & data_hit & (state_reg == cfgdec_pkg::CFGDEC_CONFIG);
   assign in_config = (state_reg == cfgdec_pkg::CFGDEC_CONFIG);
   assign cfg_port_addr = port_base;

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_rst) begin
         state_reg <= cfgdec_pkg::CFGDEC_RUN;
      end else if (io.wr && key_hit) begin
         case (state_reg)
            cfgdec_pkg::CFGDEC_RUN: begin
               if (io.wdata == cfgdec_pkg::KEY_ENTER) begin
                  state_reg <= cfgdec_pkg::CFGDEC_CONFIG;
               end
            end
            cfgdec_pkg::CFGDEC_CONFIG: begin
               if (io.wdata == cfgdec_pkg::KEY_EXIT) begin
                  state_reg <= cfgdec_pkg::CFGDEC_RUN;
               end
            end
            default: state_reg <= cfgdec_pkg::CFGDEC_RUN;
         endcase
      end
   end

   // Index: exit key write also lands here but is harmless, state leaves config
   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_rst) begin
         index_reg <= cfgdec_pkg::INDEX_RESET;
      end else if (idx_wr) begin
         index_reg <= io.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b || soft_rst) begin
         ldn_reg <= cfgdec_pkg::LDN_RESET;
      end else if (data_wr && index_reg == cfgdec_pkg::IDX_LDN) begin
         ldn_reg <= io.wdata;
      end
   end

   // Strap value lands one edge after the load strobe, so apply it a cycle later
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         strap_apply_reg <= 1'b0;
      end else begin
         strap_apply_reg <= strap_load;
      end
   end

   // Port address: strap default, software relocation afterwards
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cfg_port_addr_low  <= cfgdec_pkg::CFG_ADDR_STRAP_LOW[7:0];
         cfg_port_addr_high <= cfgdec_pkg::CFG_ADDR_STRAP_LOW[15:8];
      end else if (strap_apply_reg) begin
         cfg_port_addr_low  <= strap_reg ? cfgdec_pkg::CFG_ADDR_STRAP_HIGH[7:0]
                                         : cfgdec_pkg::CFG_ADDR_STRAP_LOW[7:0];
         cfg_port_addr_high <= strap_reg ? cfgdec_pkg::CFG_ADDR_STRAP_HIGH[15:8]
                                         : cfgdec_pkg::CFG_ADDR_STRAP_LOW[15:8];
      end else if (data_wr && index_reg == cfgdec_pkg::IDX_ADDR_LOW) begin
         cfg_port_addr_low <= io.wdata;
      end else if (data_wr && index_reg == cfgdec_pkg::IDX_ADDR_HIGH) begin
         cfg_port_addr_high <= io.wdata;
      end
   end

   // Activate bit per logical device
   genvar g;
   generate
      for (g = 0; g < NUM_LDEV; g++) begin : g_act
         always_ff @(posedge ref_clk) begin
            if (!rst_b || soft_rst) begin
               ldev_active[g] <= 1'b0;
            end else if (data_wr && index_reg == cfgdec_pkg::IDX_ACTIVATE && ldn_reg == 8'(g)) begin
               ldev_active[g] <= io.wdata[0];
            end
         end
      end
   endgenerate

   // --------------------------------------------------------------
   // Register write and read paths
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         reg_wr       <= '0;
         reg_wr_valid <= 1'b0;
      end else begin
         reg_wr_valid      <= data_wr;
         reg_wr.global_sel <= (index_reg <= cfgdec_pkg::IDX_GLOBAL_LAST);
         reg_wr.ldn        <= ldn_reg;
         reg_wr.index      <= index_reg;
         reg_wr.data       <= io.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rdata       <= 8'h00;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= data_rd;
         if (data_rd) begin
            case (index_reg)
               cfgdec_pkg::IDX_LDN:       rdata <= ldn_reg;
               cfgdec_pkg::IDX_ADDR_LOW:  rdata <= cfg_port_addr_low;
               cfgdec_pkg::IDX_ADDR_HIGH: rdata <= cfg_port_addr_high;
               cfgdec_pkg::IDX_ACTIVATE:  rdata <= {7'h00, ldev_active[ldn_reg[3:0]]};
               default:                   rdata <= reg_rdata;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   AST_RESET_RUN: assert property (soft_rst |=> !in_config && ldev_active == '0)
      else $error("not in run state after host reset");
   AST_NO_DATA_IN_RUN: assert property (!in_config |-> !data_wr && !data_rd)
      else $error("data port decoded in run state");
   AST_STRAP_ADDR: assert property (strap_apply_reg |=> cfg_port_addr ==
      ($past(strap_reg) ? cfgdec_pkg::CFG_ADDR_STRAP_HIGH : cfgdec_pkg::CFG_ADDR_STRAP_LOW))
      else $error("strap address wrong");
   AST_RELOC_LOW: assert property (data_wr && index_reg == cfgdec_pkg::IDX_ADDR_LOW && !strap_apply_reg
      |=> cfg_port_addr_low == $past(io.wdata))
      else $error("port low byte not relocated");
   AST_ENTER: assert property (!in_config && io.wr && key_hit && !soft_rst
      && io.wdata == cfgdec_pkg::KEY_ENTER |=> in_config)
      else $error("entry key ignored");
   AST_EXIT: assert property (in_config && io.wr && key_hit
      && io.wdata == cfgdec_pkg::KEY_EXIT |=> !in_config)
      else $error("exit key ignored");
   AST_LDN: assert property (data_wr && index_reg == cfgdec_pkg::IDX_LDN && !soft_rst
      |=> ldn_reg == $past(io.wdata))
      else $error("device number not stored");
   AST_RUN_OTHER: assert property (!in_config && io.wr && key_hit && !soft_rst
      && io.wdata != cfgdec_pkg::KEY_ENTER |=> !in_config && $stable(index_reg))
      else $error("run state changed by other key");
   AST_WR_OUT: assert property (data_wr |=> reg_wr_valid && reg_wr.data == $past(io.wdata))
      else $error("register write not forwarded");

   COV_ENTER: cover property (!in_config ##1 in_config);
   COV_EXIT: cover property (in_config ##1 !in_config);
   COV_RELOC: cover property (data_wr && index_reg == cfgdec_pkg::IDX_ADDR_LOW);
   COV_STRAP_HIGH: cover property (strap_apply_reg && strap_reg);
endmodule
`default_nettype wire

/* File: rtl/cfgdec_pkg.sv */
package cfgdec_pkg;

   localparam logic [15:0] CFG_ADDR_STRAP_LOW  = 16'h002e;
   localparam logic [15:0] CFG_ADDR_STRAP_HIGH = 16'h004e;
   localparam logic [7:0]  KEY_ENTER           = 8'h55;
   localparam logic [7:0]  KEY_EXIT            = 8'haa;
   localparam logic [7:0]  IDX_LDN             = 8'h07;
   localparam logic [7:0]  IDX_ADDR_LOW        = 8'h26;
   localparam logic [7:0]  IDX_ADDR_HIGH       = 8'h27;
   localparam logic [7:0]  IDX_GLOBAL_LAST     = 8'h2f;
   localparam logic [7:0]  IDX_ACTIVATE        = 8'h30;
   localparam logic [15:0] DATA_PORT_STEP      = 16'h0001;
   localparam logic [7:0]  LDN_RESET           = 8'h00;
   localparam logic [7:0]  INDEX_RESET         = 8'h00;
   localparam int          NUM_LDEV            = 16;

   typedef enum logic [0:0] {
      CFGDEC_RUN    = 1'b0,
      CFGDEC_CONFIG = 1'b1
   } cfgdec_state_t;

   // One host I/O cycle
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cfgdec_io_t;

   // Write toward a configuration register
   typedef struct packed {
      logic       global_sel;
      logic [7:0] ldn;
      logic [7:0] index;
      logic [7:0] data;
   } cfgdec_reg_wr_t;

endpackage

/* File: rtl/cfgdec_strap.sv */
`timescale 1ns/100ps
`default_nettype none
module cfgdec_strap (
   input  wire logic ref_clk,
   input  wire logic rst_b,
   input  wire logic host_bus_reset_n,
   input  wire logic strap_pin,
   output logic      strap_reg,
   output logic      host_reset_sync,
   output logic      strap_load
);
   logic [1:0] strap_sync_reg;
   logic [1:0] hrst_sync_reg;
   logic       hrst_prev_reg;
   logic       first_reg;

   // --------------------------------------------------------------
   // Synchronisers
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         hrst_sync_reg <= 2'h3;
      end else begin
         hrst_sync_reg <= {hrst_sync_reg[0], host_bus_reset_n};
      end
   end

   // Runs through reset so the power-on load sees the real pin level
   always_ff @(posedge ref_clk) begin
      strap_sync_reg <= {strap_sync_reg[0], strap_pin};
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         hrst_prev_reg <= 1'b1;
         first_reg     <= 1'b1;
      end else begin
         hrst_prev_reg <= hrst_sync_reg[1];
         first_reg     <= 1'b0;
      end
   end

   // Power-on load on the first edge after release, else falling edge of host reset
   assign strap_load      = first_reg | (hrst_prev_reg & ~hrst_sync_reg[1]);
   assign host_reset_sync = ~hrst_sync_reg[1];

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         strap_reg <= 1'b0;
      end else if (strap_load) begin
         strap_reg <= strap_sync_reg[1];
      end
   end
endmodule
`default_nettype wire

/* File: test/cfgdec_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cfgdec_host_model (
   input  wire logic             ref_clk,
   input  wire logic [7:0]       rdata,
   input  wire logic             rdata_valid,
   output cfgdec_pkg::cfgdec_io_t io
);
   initial begin
      io = '0;
   end
   // ---------------------------
   // Host I/O cycles
   // ---------------------------
   // Released lines show the inverse, so a stale address never matches
   task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d,
                        output logic v, output logic [7:0] q);
      @(posedge ref_clk);
      io <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk);
      io <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1;
      v = rdata_valid;
      q = rdata;
   endtask
   task automatic put(input logic [15:0] b, input logic [7:0] i, input logic [7:0] d);
      logic       v;
      logic [7:0] q;
      cycle(1'b1, b, i, v, q);
      cycle(1'b1, b + 16'h0001, d, v, q);
   endtask
   task automatic key(input logic [15:0] b, input logic [7:0] k);
      logic       v;
      logic [7:0] q;
      cycle(1'b1, b, k, v, q);
   endtask
endmodule
`default_nettype wire

/* File: test/config_port_decoder_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module config_port_decoder_bench;
   logic                       ref_clk, rst_b, host_bus_reset_n, gpio_in_pin;
   logic [7:0]                 reg_rdata, rdata, q;
   logic                       rdata_valid, reg_wr_valid, gpio_in, in_config, v;
   logic [15:0]                cfg_port_addr, ldev_active;
   cfgdec_pkg::cfgdec_io_t     io;
   cfgdec_pkg::cfgdec_reg_wr_t reg_wr;
   int                         miscompares, tests_run, cycles;

   cfgdec_top #(.NUM_LDEV(16)) cfgdec_top_inst (.ref_clk(ref_clk), .rst_b(rst_b),
      .host_bus_reset_n(host_bus_reset_n), .io(io), .rdata(rdata), .rdata_valid(rdata_valid),
      .reg_wr(reg_wr), .reg_wr_valid(reg_wr_valid), .reg_rdata(reg_rdata),
      .gpio_in_pin(gpio_in_pin), .gpio_in(gpio_in), .in_config(in_config),
      .cfg_port_addr(cfg_port_addr), .ldev_active(ldev_active));
   cfgdec_host_model cfgdec_host_model_inst (.ref_clk(ref_clk), .rdata(rdata),
      .rdata_valid(rdata_valid), .io(io));

   initial begin
      ref_clk = 1'b0;
   end
   always #10 ref_clk = ~ref_clk;
   // ---------------------------
   // Checking and verdict
   // ---------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ---------------------------
   // Scenarios
   // ---------------------------
   task automatic t_reset();
      check(16'(in_config), 16'h0000);
      check(cfg_port_addr, 16'h002e);
      check(ldev_active, 16'h0000);
   endtask
   task automatic t_run_ignore();
      cfgdec_host_model_inst.cycle(1'b0, 16'h002e, 8'h00, v, q);
      check(16'(v), 16'h0000);
      cfgdec_host_model_inst.cycle(1'b0, 16'h002f, 8'h00, v, q);
      check(16'(v), 16'h0000);
      cfgdec_host_model_inst.cycle(1'b1, 16'h002f, 8'h01, v, q);
      check(16'(reg_wr_valid), 16'h0000);
      cfgdec_host_model_inst.key(16'h002e, 8'haa);
      cfgdec_host_model_inst.key(16'h002e, 8'h07);
      check(16'(in_config), 16'h0000);
   endtask
   task automatic t_ldev();
      cfgdec_host_model_inst.key(16'h002e, 8'h55);
      check(16'(in_config), 16'h0001);
      // Index still at reset value, so the read falls through to reg_rdata
      cfgdec_host_model_inst.cycle(1'b0, 16'h002f, 8'h00, v, q);
      check({7'h00, v, q}, 16'h015a);
      cfgdec_host_model_inst.put(16'h002e, 8'h07, 8'h03);
      check({7'h00, reg_wr_valid, reg_wr.data}, 16'h0103);
      cfgdec_host_model_inst.key(16'h002e, 8'h07);
      cfgdec_host_model_inst.cycle(1'b0, 16'h002f, 8'h00, v, q);
      check({7'h00, v, q}, 16'h0103);
      cfgdec_host_model_inst.put(16'h002e, 8'h30, 8'h01);
      check(ldev_active, 16'h0008);
      check({reg_wr.global_sel, reg_wr.ldn[6:0], reg_wr.index}, 16'h0330);
      cfgdec_host_model_inst.cycle(1'b0, 16'h002f, 8'h00, v, q);
      check({7'h00, v, q}, 16'h0101);
      cfgdec_host_model_inst.put(16'h002e, 8'h22, 8'h5a);
      check({reg_wr.global_sel, reg_wr.index[6:0], reg_wr.data}, 16'ha25a);
      cfgdec_host_model_inst.key(16'h002e, 8'haa);
      check(16'(in_config), 16'h0000);
      cfgdec_host_model_inst.key(16'h002e, 8'h55);
      check(16'(in_config), 16'h0001);
   endtask
   task automatic t_relocate();
      cfgdec_host_model_inst.put(16'h002e, 8'h27, 8'h00);
      cfgdec_host_model_inst.put(16'h002e, 8'h26, 8'h60);
      check(cfg_port_addr, 16'h0060);
      cfgdec_host_model_inst.cycle(1'b0, 16'h0061, 8'h00, v, q);
      check({7'h00, v, q}, 16'h0160);
      cfgdec_host_model_inst.key(16'h002e, 8'haa);
      check(16'(in_config), 16'h0001);
      cfgdec_host_model_inst.key(16'h0060, 8'haa);
      check(16'(in_config), 16'h0000);
      cfgdec_host_model_inst.key(16'h0060, 8'h55);
      check(16'(in_config), 16'h0001);
   endtask
   task automatic t_strap();
      @(posedge ref_clk);
      gpio_in_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      check(16'(gpio_in), 16'h0001);
      @(posedge ref_clk);
      host_bus_reset_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      host_bus_reset_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      check(cfg_port_addr, 16'h004e);
      check(16'(in_config), 16'h0000);
      check(ldev_active, 16'h0000);
      @(posedge ref_clk);
      gpio_in_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      check(16'(gpio_in), 16'h0000);
      check(cfg_port_addr, 16'h004e);
      cfgdec_host_model_inst.key(16'h004e, 8'h55);
      check(16'(in_config), 16'h0001);
      cfgdec_host_model_inst.key(16'h004e, 8'haa);
   endtask
   // ---------------------------
   // Main sequence
   // ---------------------------
   initial begin
      rst_b = 1'b0;
      host_bus_reset_n = 1'b1;
      gpio_in_pin = 1'b0;
      reg_rdata = 8'h5a;
      miscompares = 0;
      tests_run = 0;
      cycles = 0;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      t_reset();
      t_run_ignore();
      t_ldev();
      t_relocate();
      t_strap();
      give_verdict();
   end
endmodule
`default_nettype wire
